/* hdl/osc_clock_ctrl.sv */
// Programmable clock control: clock RAM, generator loader, dividers, meter.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module osc_clock_ctrl
   import osc_ctrl_pkg::*;
#(
   parameter int MEAS_GATE = MEAS_GATE_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic [NUM_CH-1:0] gen_clk_i,
   output logic [NUM_CH-1:0] baud_clk_o,
   output logic ser_clk_o,
   input wire logic ser_dat_i,
   output logic ser_dat_o,
   output logic ser_dat_oe_n_o
);

   //------------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------------
   logic [7:0] ram [256];
   logic [7:0] ram_addr;
   ctrl_t ctrl;
   ctrl_t next_ctrl;
   logic [NUM_CH-1:0][DIV_W-1:0] div;
   logic [31:0] wmask;
   logic bus_req;
   logic bus_wr;
   logic ctrl_wr;
   logic [31:0] rd_val;
   logic [31:0] status;
   logic prog_done;
   logic prog_err;
   logic prog_start;
   ser_state_t state;
   logic [8:0] qcnt;
   logic tick;
   logic [1:0] ph;
   logic [3:0] bitcnt;
   logic [8:0] shreg;
   logic [6:0] byte_idx;
   logic [7:0] cur_byte;
   logic scl;
   logic sda_low;
   logic fail;
   logic ser_end;
   logic [NUM_CH-1:0] fin_prev;
   logic [NUM_CH-1:0] fin_rise;
   logic meas_start;
   logic [1:0] next_meas_ch;
   logic [1:0] meas_ch;
   logic meas_run;
   logic meas_done;
   logic meas_end;
   logic [31:0] gate_cnt;
   logic [23:0] edge_cnt;
   logic [23:0] meas_val;
   logic [NUM_EV-1:0] irq_stat;
   logic [NUM_EV-1:0] irq_mask;
   logic [NUM_EV-1:0] irq_ev;

   //------------------------------------------------------------------
   // Wishbone slave
   //------------------------------------------------------------------
   // Every access is answered one cycle after it is presented; writes
   // land on the acknowledge edge, read data is captured one edge before.
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
   assign ctrl_wr = bus_wr && (wb_adr_i == OFS_CTRL);
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign next_ctrl = (ctrl & ~wmask) | (wb_dat_i & wmask);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   assign status = {ctrl.rb_ctrl ? 24'(ctrl[23:0]) : meas_val,
                    5'h00, meas_done, prog_err, prog_done};

   always_comb begin
      case (wb_adr_i)
         OFS_RAM_ADDR: rd_val = {24'h000000, ram_addr};
         OFS_RAM_DATA: rd_val = {24'h000000, ram[ram_addr]};
         OFS_CTRL: rd_val = status;
         OFS_IRQ_STAT: rd_val = {29'h0, irq_stat};
         OFS_IRQ_MASK: rd_val = {29'h0, irq_mask};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= rd_val;
      end
   end

   //------------------------------------------------------------------
   // Clock RAM and its address register
   //------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ram_addr <= RAM_ADDR_RST;
      end else if (bus_wr && wb_adr_i == OFS_RAM_ADDR && wb_sel_i[0]) begin
         ram_addr <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 256; i++) begin
            ram[i] <= ram_default(8'(i));
         end
      end else if (bus_wr && wb_adr_i == OFS_RAM_DATA && wb_sel_i[0]) begin
         ram[ram_addr] <= wb_dat_i[7:0];
      end
   end

   //------------------------------------------------------------------
   // Control word and post-divider settings
   //------------------------------------------------------------------
   // The start bit is never stored, so it always reads back as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl <= next_ctrl;
         ctrl.prog <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= '0;
      end else if (ctrl_wr && next_ctrl.div_set) begin
         div <= next_ctrl.div;
      end
   end

   //------------------------------------------------------------------
   // Post-dividers and final baud clocks
   //------------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_div
      pow2_divider u_div (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .gen_clk_i(gen_clk_i[c]),
         .div_i(div[c]),
         .fin_o(baud_clk_o[c])
      );
   end

   //------------------------------------------------------------------
   // Programming status
   //------------------------------------------------------------------
   assign prog_start = ctrl_wr && next_ctrl.prog && state == S_IDLE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog_done <= 1'b0;
         prog_err <= 1'b0;
      end else if (prog_start) begin
         prog_done <= 1'b0;
         prog_err <= 1'b0;
      end else if (ser_end) begin
         prog_done <= 1'b1;
         prog_err <= fail;
      end
   end

   //------------------------------------------------------------------
   // Serial loader for the clock generator
   //------------------------------------------------------------------
   // Sends address byte, register pointer, then mapped RAM bytes in order.
   // A missing acknowledge on any byte ends the transfer with a failure.
   assign tick = (qcnt == 9'(SER_QUARTER_CYC - 1));
   assign ser_clk_o = scl;
   assign ser_dat_o = 1'b0;
   assign ser_dat_oe_n_o = ~sda_low;

   always_comb begin
      case (byte_idx)
         7'd0: cur_byte = {GEN_DEV_ADDR, 1'b0};
         7'd1: cur_byte = MAP_FIRST;
         default: cur_byte = ram[8'(byte_idx) - 8'd2 + MAP_FIRST];
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || state == S_IDLE || tick) begin
         qcnt <= '0;
      end else begin
         qcnt <= qcnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         ph <= 2'd0;
         bitcnt <= 4'd0;
         shreg <= '0;
         byte_idx <= 7'd0;
         scl <= 1'b1;
         sda_low <= 1'b0;
         fail <= 1'b0;
         ser_end <= 1'b0;
      end else begin
         ser_end <= 1'b0;
         case (state)
            S_IDLE: begin
               if (prog_start) begin
                  state <= S_START;
                  ph <= 2'd0;
                  byte_idx <= 7'd0;
                  fail <= 1'b0;
               end
            end
            S_START: begin
               if (tick) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd0) begin
                     sda_low <= 1'b1;
                  end else if (ph == 2'd1) begin
                     scl <= 1'b0;
                  end else begin
                     state <= S_BIT;
                     ph <= 2'd0;
                     shreg <= {cur_byte, 1'b1};
                     bitcnt <= 4'd0;
                     byte_idx <= byte_idx + 7'd1;
                  end
               end
            end
            S_BIT: begin
               if (tick) begin
                  ph <= ph + 2'd1;
                  case (ph)
                     2'd0: sda_low <= ~shreg[8];
                     2'd1: scl <= 1'b1;
                     2'd2: begin
                        if (bitcnt == 4'd8 && ser_dat_i) begin
                           fail <= 1'b1;
                        end
                     end
                     default: begin
                        scl <= 1'b0;
                        if (bitcnt != 4'd8) begin
                           shreg <= {shreg[7:0], 1'b1};
                           bitcnt <= bitcnt + 4'd1;
                        end else if (fail || byte_idx == NUM_BYTES) begin
                           state <= S_STOP;
                        end else begin
                           shreg <= {cur_byte, 1'b1};
                           bitcnt <= 4'd0;
                           byte_idx <= byte_idx + 7'd1;
                        end
                     end
                  endcase
               end
            end
            S_STOP: begin
               if (tick) begin
                  ph <= ph + 2'd1;
                  case (ph)
                     2'd0: sda_low <= 1'b1;
                     2'd1: scl <= 1'b1;
                     2'd2: sda_low <= 1'b0;
                     default: begin
                        state <= S_IDLE;
                        ser_end <= 1'b1;
                     end
                  endcase
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------------
   // Clock measurement
   //------------------------------------------------------------------
   // Rising edges of the final clock are counted over a gate of 100 ms,
   // so the count is the frequency divided by ten. The lowest selected
   // channel wins when several select bits are set.
   assign meas_start = ctrl_wr && (next_ctrl.meas_sel != '0);
   assign fin_rise = baud_clk_o & ~fin_prev;
   assign meas_end = meas_run && (gate_cnt == 32'(MEAS_GATE - 1));

   always_comb begin
      next_meas_ch = 2'd0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (next_ctrl.meas_sel[i]) begin
            next_meas_ch = 2'(i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fin_prev <= '0;
      end else begin
         fin_prev <= baud_clk_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meas_run <= 1'b0;
         meas_done <= 1'b0;
         meas_ch <= 2'd0;
         gate_cnt <= '0;
         edge_cnt <= '0;
         meas_val <= '0;
      end else if (meas_start) begin
         meas_run <= 1'b1;
         meas_done <= 1'b0;
         meas_ch <= next_meas_ch;
         gate_cnt <= '0;
         edge_cnt <= '0;
      end else if (meas_run) begin
         gate_cnt <= gate_cnt + 32'd1;
         edge_cnt <= edge_cnt + 24'(fin_rise[meas_ch]);
         if (meas_end) begin
            meas_run <= 1'b0;
            meas_done <= 1'b1;
            meas_val <= edge_cnt + 24'(fin_rise[meas_ch]);
         end
      end
   end

   //------------------------------------------------------------------
   // Interrupts
   //------------------------------------------------------------------
   assign irq_ev = {meas_end, ser_end && fail, ser_end};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= IRQ_RST;
      end else if (bus_wr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0]) begin
         irq_stat <= (irq_stat & ~wb_dat_i[NUM_EV-1:0]) | irq_ev;
      end else begin
         irq_stat <= irq_stat | irq_ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= IRQ_RST;
      end else if (bus_wr && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask <= wb_dat_i[NUM_EV-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start_cmd;
      ctrl_wr && next_ctrl.prog && state == S_IDLE;
   endsequence

   sequence s_nack;
      state == S_BIT && tick && ph == 2'd2 && bitcnt == 4'd8 && ser_dat_i;
   endsequence

   property p_start_runs;
      s_start_cmd |=> state == S_START && ctrl.prog == 1'b0;
   endproperty
   a_start_runs: assert property (p_start_runs)
      else $error("programming did not start or start bit stuck");

   property p_done_low;
      state != S_IDLE |-> !prog_done;
   endproperty
   a_done_low: assert property (p_done_low)
      else $error("done bit set during programming");

   property p_start_clears;
      s_start_cmd |=> !prog_done && !prog_err;
   endproperty
   a_start_clears: assert property (p_start_clears)
      else $error("start did not clear done and error");

   sequence s_fail_end;
      ser_end && fail;
   endsequence

   // The stop condition follows one quarter bit after the refused byte.
   property p_nack_err;
      s_nack |-> ##[1:300] state == S_STOP && fail;
   endproperty
   a_nack_err: assert property (p_nack_err)
      else $error("missing acknowledge did not end the transfer");

   property p_err_report;
      s_fail_end |=> prog_err && prog_done;
   endproperty
   a_err_report: assert property (p_err_report)
      else $error("failed transfer not reported as error");

   property p_pins_idle;
      state == S_IDLE |-> scl && ser_dat_oe_n_o;
   endproperty
   a_pins_idle: assert property (p_pins_idle)
      else $error("serial pins active while idle");

   property p_div_keep;
      ctrl_wr && !next_ctrl.div_set |=> $stable(div);
   endproperty
   a_div_keep: assert property (p_div_keep)
      else $error("dividers changed without set bit");

   property p_div_load;
      ctrl_wr && next_ctrl.div_set |=> div == $past(next_ctrl.div);
   endproperty
   a_div_load: assert property (p_div_load)
      else $error("dividers not loaded from control word");

   property p_meas_clear;
      meas_start |=> !meas_done && meas_run;
   endproperty
   a_meas_clear: assert property (p_meas_clear)
      else $error("measurement start did not clear complete bit");

   property p_meas_value;
      meas_end |=> meas_done && meas_val == $past(edge_cnt)
         + 24'($past(fin_rise[meas_ch]));
   endproperty
   a_meas_value: assert property (p_meas_value)
      else $error("measurement result wrong");

   property p_readback;
      bus_req && !wb_we_i && wb_adr_i == OFS_CTRL && ctrl.rb_ctrl
         |=> wb_dat_o[31:8] == $past(ctrl[23:0]);
   endproperty
   a_readback: assert property (p_readback)
      else $error("status readback does not show control word");

endmodule

/* hdl/osc_ctrl_pkg.sv */
// Constants, types and defaults for the programmable clock control block.
package osc_ctrl_pkg;

   //------------------------------------------------------------------
   // Register map
   //------------------------------------------------------------------
   localparam logic [7:0] OFS_RAM_ADDR = 8'hA0;
   localparam logic [7:0] OFS_RAM_DATA = 8'hA4;
   localparam logic [7:0] OFS_CTRL = 8'hA8;
   localparam logic [7:0] OFS_IRQ_STAT = 8'hAC;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hB0;

   // Status word bit positions and interrupt event positions.
   localparam int ST_PROG_DONE = 0;
   localparam int ST_PROG_ERR = 1;
   localparam int ST_MEAS_DONE = 2;
   localparam int NUM_EV = 3;
   localparam logic [NUM_EV-1:0] IRQ_RST = 3'h0;

   localparam int NUM_CH = 4;
   localparam int DIV_W = 4;
   localparam int DIV_CNT_W = 15;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] RAM_ADDR_RST = 8'h00;

   //------------------------------------------------------------------
   // Generator serial transfer
   //------------------------------------------------------------------
   localparam logic [7:0] MAP_FIRST = 8'h08;
   localparam logic [7:0] MAP_LAST = 8'h57;
   // Device address on the serial bus; the value is arbitrary.
   localparam logic [6:0] GEN_DEV_ADDR = 7'h55;
   // Address byte, register pointer byte, then one byte per mapped entry.
   localparam logic [6:0] NUM_BYTES = 7'(2 + MAP_LAST - MAP_FIRST + 1);

   //------------------------------------------------------------------
   // Timing
   //------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SER_QUARTER_NS = 2500;
   localparam int SER_QUARTER_CYC =
      (SER_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MEAS_GATE_NS = 100_000_000;
   localparam int MEAS_GATE_CYC = MEAS_GATE_NS / CLK_PERIOD_NS;

   //------------------------------------------------------------------
   // Types
   //------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rsv_hi;
      logic [NUM_CH-1:0][DIV_W-1:0] div;
      logic div_set;
      logic rb_ctrl;
      logic rsv5;
      logic [NUM_CH-1:0] meas_sel;
      logic prog;
   } ctrl_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_START = 2'b01,
      S_BIT = 2'b10,
      S_STOP = 2'b11
   } ser_state_t;

   // Contents of the clock RAM after reset.
   function automatic logic [7:0] ram_default(input logic [7:0] a);
      case (a)
         8'h06: ram_default = 8'hD2;
         8'h07: ram_default = 8'h08;
         8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D: ram_default = 8'h01;
         8'h0F: ram_default = 8'h50;
         8'h10: ram_default = 8'h55;
         8'h1A: ram_default = 8'hE9;
         8'h1B: ram_default = 8'h08;
         default: ram_default = 8'h00;
      endcase
   endfunction

endpackage

/* hdl/pow2_divider.sv */
// Power-of-two post-divider for one generator output channel.
`timescale 1ns/1ps
module pow2_divider
   import osc_ctrl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic gen_clk_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic fin_o
);

   logic gen_prev;
   logic [DIV_CNT_W-1:0] cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gen_prev <= 1'b0;
         cnt <= '0;
      end else begin
         gen_prev <= gen_clk_i;
         if (gen_clk_i && !gen_prev) begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // Counter bit n-1 has a period of 2^n generator periods.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fin_o <= 1'b0;
      end else if (div_i == '0) begin
         fin_o <= gen_clk_i;
      end else begin
         fin_o <= cnt[div_i - 1'b1];
      end
   end

endmodule

/* sim/gen_model.sv */
// Behavioural model of the external clock generator's serial port.
`timescale 1ns/1ps
module gen_model (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [6:0] nack_at_i,
   output logic pull_o,
   output logic [6:0] nbytes_o,
   output logic [15:0] first_o
);
   logic ps = 1'b1;
   logic pd = 1'b1;
   logic [3:0] bits = 4'h0;
   logic [7:0] sh = 8'h00;
   logic pull = 1'b0;
   logic [6:0] nbytes = 7'h00;
   logic [15:0] first = 16'h0000;
   assign pull_o = pull;
   assign nbytes_o = nbytes;
   assign first_o = first;
   // Bytes come MSB first; the ninth clock carries our acknowledge.
   always @(posedge clk_i) begin
      ps <= scl_i;
      pd <= sda_i;
      if (ps && scl_i && pd && !sda_i) begin
         bits <= 4'h0;
         nbytes <= 7'h00;
         first <= 16'h0000;
         pull <= 1'b0;
      end else if (!ps && scl_i) begin
         bits <= bits + 4'h1;
         if (bits < 4'h8) sh <= {sh[6:0], sda_i};
      end else if (ps && !scl_i && bits == 4'h8) begin
         pull <= nbytes < nack_at_i;
         nbytes <= nbytes + 7'h01;
         if (nbytes < 7'h02) first <= {first[7:0], sh};
      end else if (ps && !scl_i && bits == 4'h9) begin
         pull <= 1'b0;
         bits <= 4'h0;
      end
   end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the programmable clock control block.
`timescale 1ns/1ps
module tb_top;
   import osc_ctrl_pkg::*;
   localparam int GATE = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack, irq, scl, dout, doe_n, pull;
   logic [1:0] gcnt = 2'h0;
   logic [3:0] baud;
   logic [6:0] nack_at = 7'h00;
   logic [6:0] nb;
   logic [15:0] first;
   int fails = 0;
   int compares = 0;
   wire logic sda = ~(~doe_n | pull);

   osc_clock_ctrl #(.MEAS_GATE(GATE)) dut (.clk_i(clk), .rst_i(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .gen_clk_i({4{gcnt[1]}}), .baud_clk_o(baud),
      .ser_clk_o(scl), .ser_dat_i(sda), .ser_dat_o(dout),
      .ser_dat_oe_n_o(doe_n));
   gen_model gen (.clk_i(clk), .scl_i(scl), .sda_i(sda),
      .nack_at_i(nack_at), .pull_o(pull), .nbytes_o(nb),
      .first_o(first));

   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) gcnt <= gcnt + 2'h1;

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         rd(OFS_CTRL);
         n++;
      end while (q[b] !== 1'b1 && n < 20000);
   endtask

   task automatic t_regs;
      logic [7:0] a[5] = '{8'h06, 8'h08, 8'h0F, 8'h1A, 8'h57};
      logic [7:0] e[5] = '{8'hD2, 8'h01, 8'h50, 8'hE9, 8'h00};
      rd(OFS_CTRL);
      chk(q, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_RAM_ADDR, {24'h0, a[i]});
         rd(OFS_RAM_DATA);
         chk(q[7:0], e[i]);
      end
      wr(OFS_RAM_ADDR, 32'h40);
      wr(OFS_RAM_DATA, 32'h5A);
      rd(OFS_RAM_ADDR);
      chk(q[7:0], 8'h40);
      rd(OFS_RAM_DATA);
      chk(q[7:0], 8'h5A);
      rd(8'hB4);
      chk(q, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_meas;
      int n[4] = '{0, 2, 1, 3};
      int x;
      wr(OFS_CTRL, 32'h0031_2080);
      wr(OFS_CTRL, 32'h0031_2040);
      rd(OFS_CTRL);
      chk(q[31:8], 24'h31_2040);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_IRQ_MASK, (c == 3) ? 32'h0 : 32'h7);
         wr(OFS_CTRL, 32'h2 << c); // Dividers must survive this write.
         rd(OFS_CTRL);
         chk(q[2], 1'b0);
         poll(ST_MEAS_DONE);
         x = GATE / (4 << n[c]);
         chk(q[31:8] >= x - 1 && q[31:8] <= x + 1, 1'b1);
         chk(q[31:8] >= x - 1 && q[31:8] <= x + 1, 1'b1);
         rd(OFS_IRQ_STAT);
         chk(q[2:0], 3'h4);
         chk(irq, c != 3);
         wr(OFS_IRQ_STAT, 32'h7);
         rd(OFS_IRQ_STAT);
         chk({irq, q[2:0]}, 4'h0);
      end
      $display("test measure done");
   endtask

   task automatic t_prog(input logic [6:0] k);
      nack_at <= k;
      wr(OFS_IRQ_MASK, 32'h7);
      wr(OFS_CTRL, 32'h41);
      rd(OFS_CTRL);
      chk(q[1:0], 2'h0);
      chk(q[8], 1'b0);
      poll(ST_PROG_DONE);
      chk(q[1:0], 2'h3);
      chk(nb, k + 7'h01);
      chk(first, k ? {GEN_DEV_ADDR, 1'b0, MAP_FIRST}
                   : {8'h00, GEN_DEV_ADDR, 1'b0});
      chk({scl, sda}, 2'h3);
      chk(dout, 1'b0);
      rd(OFS_IRQ_STAT);
      chk({irq, q[2:0]}, 4'hB);
      wr(OFS_IRQ_STAT, 32'h7);
      $display("test program done");
   endtask

   task automatic final_report;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      final_report;
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_meas;
      t_prog(7'h01);
      t_prog(7'h00);
      final_report;
   end
endmodule
